// *** hw/irq_ctrl_regs.vh ***
`ifndef IRQ_CTRL_REGS_VH
`define IRQ_CTRL_REGS_VH

// -----------------------------------------------------------------
// Register byte offsets on the bus.
// -----------------------------------------------------------------
`define OFS_ENABLE      8'h00
`define OFS_PRIO_LOW    8'h04
`define OFS_PRIO_HIGH   8'h08
`define OFS_FLAGS       8'h0C
`define OFS_CONTROL     8'h10
`define OFS_STATUS      8'h14

// -----------------------------------------------------------------
// Field positions.
// -----------------------------------------------------------------
`define EN_PF_BIT       12
`define EN_GLOBAL_BIT   15
`define CTL_EDGE_A      0
`define CTL_EDGE_B      1
`define CTL_CAPTURE     2
`define CTL_T2_EXT_EN   3
`define CTL_UPDOWN      4
`define FLG_EXT_A       1
`define FLG_TF0         2
`define FLG_EXT_B       3
`define FLG_TF1         4
`define FLG_RI0         5
`define FLG_TI0         6
`define FLG_TF2         7
`define FLG_TIMER2_EXTERNAL_FLAG        8
`define FLG_RI1         9
`define FLG_TI1         10
`define FLG_EXT_C       11
`define FLG_EXT_D       12
`define FLG_EXT_E       13
`define FLG_EXT_F       14
`define FLG_WDT         15

// -----------------------------------------------------------------
// Reset values.
// -----------------------------------------------------------------
`define ENABLE_RST      16'h0000
`define PRIO_RST        12'h000
`define FLAGS_RST       15'h0000
`define CONTROL_RST     5'h00

// -----------------------------------------------------------------
// Sources, vectors and timing.
// -----------------------------------------------------------------
`define NUM_SRC         12
`define SRC_PF          4'hC
`define SRC_SP1         4'h6
`define VEC_BASE        8'h03
`define VEC_PF          8'h33
`define LVL_PF          3'h4
`define PM_DIV_CYCLES   1024
`define PM_CNT_W        10

`endif

// *** hw/edge_sampler.v ***
`timescale 1ns/10ps
`default_nettype none

// Samples a pin on each enable and flags a change from the idle level
// to the active level seen on two successive samples.
module edge_sampler #(
	parameter RISING = 0	// 1 detects low-to-high, 0 high-to-low.
) (
	input  wire mclk,
	input  wire srst,
	input  wire sample_en,
	input  wire pin,
	output wire edge_seen
);

	localparam [0:0] IDLE_LVL = (RISING != 0) ? 1'b0 : 1'b1;

	reg last_reg;	// Previous sample of the pin.

	// -------------------------------------------------------------
	// Sample history.
	// -------------------------------------------------------------
	// Reset to the idle level so that no false edge appears.
	always @(posedge mclk) begin
		if (srst) begin
			last_reg <= IDLE_LVL;
		end else if (sample_en) begin
			last_reg <= pin;
		end
	end

	// An edge is idle on the last sample and active on this one.
	assign edge_seen = sample_en & (last_reg == IDLE_LVL) &
		(pin != IDLE_LVL);

endmodule // edge_sampler

`default_nettype wire

// *** hw/irq_ctrl.v ***
`timescale 1ns/10ps
`default_nettype none
`include "irq_ctrl_regs.vh"

module irq_ctrl (
	input  wire        mclk,
	input  wire        srst,
	// AHB-Lite slave.
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	// Instruction sequencer.
	input  wire        last_cycle,
	input  wire        insn_return_from_interrupt,
	input  wire        insn_cfg_write,
	input  wire        pm_mode,
	output reg         call_req,
	output reg  [7:0]  call_vector,
	// Pins and peripheral events.
	input  wire        ext_irq_a_n,
	input  wire        ext_irq_b_n,
	input  wire        ext_irq_c,
	input  wire        ext_irq_d_n,
	input  wire        ext_irq_e,
	input  wire        ext_irq_f_n,
	input  wire        timer2_trigger_pin,
	input  wire        timer0_overflow,
	input  wire        timer1_overflow,
	input  wire        timer2_overflow,
	input  wire        serial0_rx_done,
	input  wire        serial0_tx_done,
	input  wire        serial1_rx_done,
	input  wire        serial1_tx_done,
	input  wire        watchdog_event,
	input  wire        supply_warning_level
);

	// -------------------------------------------------------------
	// Declarations.
	// -------------------------------------------------------------
	reg  [15:0] enable_reg;     // Source enables, pf and global.
	reg  [11:0] prio_low_reg;   // Low-order priority bits.
	reg  [11:0] prio_high_reg;  // High-order priority bits.
	reg  [15:1] flag_reg;       // Sticky interrupt flags.
	reg  [4:0]  control_reg;    // Detection and timer 2 modes.
	reg  [4:0]  isr_reg;        // One bit per level in service.
	reg  [7:0]  addr_reg;       // Data-phase address.
	reg         wr_pend_reg;    // Data-phase write pending.
	reg  [`PM_CNT_W-1:0] div_reg; // Slow clock divider.
	reg  [15:1] flag_next;
	reg  [4:0]  isr_next;
	reg  [11:0] src_req;        // Gated requests, natural order.
	reg         sel_found;
	reg  [3:0]  sel_idx;
	reg  [2:0]  sel_lvl;
	reg  [2:0]  isr_top;        // Top level in service plus one.
	reg  [3:0]  vidx;
	reg  [31:0] rd_mux;
	integer     i;
	wire        sample_en;
	wire [5:0]  ext_edge;
	wire        t2_edge;
	wire        edge_a;
	wire        edge_b;
	wire [11:0] src_flag;
	wire        pf_req;
	wire        take;
	wire        return_from_interrupt_now;
	wire        wr_enable;
	wire        wr_prio_low;
	wire        wr_prio_high;
	wire        wr_flags;
	wire        wr_control;
	wire        ahb_start;
	wire [2:0]  lvl_p1;
	wire [7:0]  sel_vector;
	wire [5:0]  ext_pins;
	integer     j;          // Loop index of the service scan.

	// -------------------------------------------------------------
	// Sample strobe.
	// -------------------------------------------------------------
	// In power management mode pins are sampled once per slowed
	// clock, so an edge is seen at the next sample, one slow period at most.
	always @(posedge mclk) begin
		if (srst || !pm_mode) begin
			div_reg <= {`PM_CNT_W{1'b0}};
		end else begin
			div_reg <= div_reg + {{(`PM_CNT_W-1){1'b0}}, 1'b1};
		end
	end

	// Full speed samples every clock; slow mode on wrap.
	assign sample_en = !pm_mode ||
		(div_reg == `PM_DIV_CYCLES - 1);

	// -------------------------------------------------------------
	// Pin edge detectors.
	// -------------------------------------------------------------
	assign ext_pins = {ext_irq_f_n, ext_irq_e, ext_irq_d_n,
		ext_irq_c, ext_irq_b_n, ext_irq_a_n};
	// Pins c and e detect rising edges, the others falling.
	localparam [5:0] EXT_RISE = 6'b010100;

	genvar g;
	generate
		for (g = 0; g < 6; g = g + 1) begin : g_ext
			edge_sampler #(
				.RISING (EXT_RISE[g])
			) u_edge (
				.mclk      (mclk),
				.srst      (srst),
				.sample_en (sample_en),
				.pin       (ext_pins[g]),
				.edge_seen (ext_edge[g])
			);
		end
	endgenerate

	// Timer 2 trigger pin, falling edge.
	edge_sampler #(
		.RISING (0)
	) u_t2_edge (
		.mclk      (mclk),
		.srst      (srst),
		.sample_en (sample_en),
		.pin       (timer2_trigger_pin),
		.edge_seen (t2_edge)
	);

	assign edge_a = control_reg[`CTL_EDGE_A];
	assign edge_b = control_reg[`CTL_EDGE_B];

	// -------------------------------------------------------------
	// Bus decode.
	// -------------------------------------------------------------
	assign ahb_start = hsel && htrans[1] && hready;
	assign wr_enable = wr_pend_reg && (addr_reg == `OFS_ENABLE);
	assign wr_prio_low = wr_pend_reg && (addr_reg == `OFS_PRIO_LOW);
	assign wr_prio_high = wr_pend_reg &&
		(addr_reg == `OFS_PRIO_HIGH);
	assign wr_flags = wr_pend_reg && (addr_reg == `OFS_FLAGS);
	assign wr_control = wr_pend_reg && (addr_reg == `OFS_CONTROL);

	// -------------------------------------------------------------
	// Effective flags and requests.
	// -------------------------------------------------------------
	// In level mode the flag is the live pin and holds no memory;
	// otherwise it is the sticky bit.
	assign src_flag[0] = edge_a ? flag_reg[`FLG_EXT_A] : !ext_irq_a_n;
	assign src_flag[1] = flag_reg[`FLG_TF0];
	assign src_flag[2] = edge_b ? flag_reg[`FLG_EXT_B] : !ext_irq_b_n;
	assign src_flag[3] = flag_reg[`FLG_TF1];
	assign src_flag[4] = flag_reg[`FLG_RI0] | flag_reg[`FLG_TI0];
	assign src_flag[5] = flag_reg[`FLG_TF2] | flag_reg[`FLG_TIMER2_EXTERNAL_FLAG];
	assign src_flag[6] = flag_reg[`FLG_RI1] | flag_reg[`FLG_TI1];
	assign src_flag[10:7] = flag_reg[`FLG_EXT_F:`FLG_EXT_C];
	assign src_flag[11] = flag_reg[`FLG_WDT];

	// Power-fail needs only its own enable.
	assign pf_req = supply_warning_level & enable_reg[`EN_PF_BIT];

	// Global enable gates every other source.
	always @* begin
		src_req = src_flag & enable_reg[11:0] &
			{12{enable_reg[`EN_GLOBAL_BIT]}};
	end

	// -------------------------------------------------------------
	// Priority decode.
	// -------------------------------------------------------------
	// Strictly greater keeps the first in natural order on a tie;
	// power-fail overrides at the fixed top level.
	always @* begin
		sel_found = 1'b0;
		sel_idx = 4'h0;
		sel_lvl = 3'h0;
		for (i = 0; i < `NUM_SRC; i = i + 1) begin
			if (src_req[i] && (!sel_found ||
				{1'b0, prio_high_reg[i], prio_low_reg[i]} >
				sel_lvl)) begin
				sel_found = 1'b1;
				sel_idx = i[3:0];
				sel_lvl = {1'b0, prio_high_reg[i], prio_low_reg[i]};
			end
		end
		if (pf_req) begin
			sel_found = 1'b1;
			sel_idx = `SRC_PF;
			sel_lvl = `LVL_PF;
		end
	end

	// Highest level in service, plus one; zero when idle.
	always @* begin
		isr_top = 3'h0;
		for (j = 0; j < 5; j = j + 1) begin
			if (isr_reg[j]) begin
				isr_top = j[2:0] + 3'h1;
			end
		end
	end

	// Vectors step by eight in natural order, skipping the slot
	// that belongs to power-fail.
	always @* begin
		if (sel_idx >= `SRC_SP1) begin
			vidx = sel_idx + 4'h1;
		end else begin
			vidx = sel_idx;
		end
	end

	assign sel_vector = (sel_idx == `SRC_PF) ? `VEC_PF :
		`VEC_BASE + {1'b0, vidx, 3'b000};

	assign lvl_p1 = sel_lvl + 3'h1;

	// Take only on the last cycle, outside return and configuration
	// writes, with a strictly higher level.
	assign take = last_cycle && !insn_return_from_interrupt && !insn_cfg_write &&
		!wr_enable && !wr_prio_low && !wr_prio_high &&
		sel_found && (lvl_p1 > isr_top);
	assign return_from_interrupt_now = last_cycle && insn_return_from_interrupt;

	// -------------------------------------------------------------
	// Flag next state.
	// -------------------------------------------------------------
	// A software write stores its value, vectoring clears TF0, TF1 and
	// edge-mode flags a and b, and hardware sets are applied last.
	always @* begin
		if (wr_flags) begin
			flag_next = hwdata[15:1];
		end else begin
			flag_next = flag_reg;
		end
		if (take) begin
			if (sel_idx == 4'h0 && edge_a) begin
				flag_next[`FLG_EXT_A] = 1'b0;
			end
			if (sel_idx == 4'h1) begin
				flag_next[`FLG_TF0] = 1'b0;
			end
			if (sel_idx == 4'h2 && edge_b) begin
				flag_next[`FLG_EXT_B] = 1'b0;
			end
			if (sel_idx == 4'h3) begin
				flag_next[`FLG_TF1] = 1'b0;
			end
		end
		// Level mode keeps no record of the pin.
		if (!edge_a) begin
			flag_next[`FLG_EXT_A] = 1'b0;
		end
		if (!edge_b) begin
			flag_next[`FLG_EXT_B] = 1'b0;
		end
		flag_next[`FLG_EXT_A] = flag_next[`FLG_EXT_A] |
			(edge_a & ext_edge[0]);
		flag_next[`FLG_EXT_B] = flag_next[`FLG_EXT_B] |
			(edge_b & ext_edge[1]);
		flag_next[`FLG_EXT_F:`FLG_EXT_C] =
			flag_next[`FLG_EXT_F:`FLG_EXT_C] | ext_edge[5:2];
		flag_next[`FLG_TF0] = flag_next[`FLG_TF0] | timer0_overflow;
		flag_next[`FLG_TF1] = flag_next[`FLG_TF1] | timer1_overflow;
		flag_next[`FLG_TF2] = flag_next[`FLG_TF2] | timer2_overflow;
		flag_next[`FLG_TIMER2_EXTERNAL_FLAG] = flag_next[`FLG_TIMER2_EXTERNAL_FLAG] | (t2_edge &
			control_reg[`CTL_T2_EXT_EN] &
			(control_reg[`CTL_CAPTURE] |
			!control_reg[`CTL_UPDOWN]));
		// Serial flags are left alone when serviced.
		flag_next[`FLG_RI0] = flag_next[`FLG_RI0] | serial0_rx_done;
		flag_next[`FLG_TI0] = flag_next[`FLG_TI0] | serial0_tx_done;
		flag_next[`FLG_RI1] = flag_next[`FLG_RI1] | serial1_rx_done;
		flag_next[`FLG_TI1] = flag_next[`FLG_TI1] | serial1_tx_done;
		flag_next[`FLG_WDT] = flag_next[`FLG_WDT] | watchdog_event;
	end

	// -------------------------------------------------------------
	// Service state next value.
	// -------------------------------------------------------------
	// A return clears the top level; a call marks the new one.
	always @* begin
		isr_next = isr_reg;
		if (return_from_interrupt_now && isr_top != 3'h0) begin
			isr_next[isr_top - 3'h1] = 1'b0;
		end
		if (take) begin
			isr_next[sel_lvl] = 1'b1;
		end
	end

	// -------------------------------------------------------------
	// State registers.
	// -------------------------------------------------------------
	always @(posedge mclk) begin
		if (srst) begin
			enable_reg <= `ENABLE_RST;
			prio_low_reg <= `PRIO_RST;
			prio_high_reg <= `PRIO_RST;
			flag_reg <= `FLAGS_RST;
			control_reg <= `CONTROL_RST;
			isr_reg <= 5'h00;
			call_req <= 1'b0;
			call_vector <= 8'h00;
		end else begin
			if (wr_enable) begin
				enable_reg <= hwdata[15:0];
			end
			if (wr_prio_low) begin
				prio_low_reg <= hwdata[11:0];
			end
			if (wr_prio_high) begin
				prio_high_reg <= hwdata[11:0];
			end
			if (wr_control) begin
				control_reg <= hwdata[4:0];
			end
			flag_reg <= flag_next;
			isr_reg <= isr_next;
			// Call is forced in the cycle after the decision.
			call_req <= take;
			if (take) begin
				call_vector <= sel_vector;
			end
		end
	end

	// -------------------------------------------------------------
	// Bus slave.
	// -------------------------------------------------------------
	// Read data is prepared in the address phase so it stands in
	// the data phase; unmapped reads return zero.
	always @* begin
		case (haddr[7:0])
			`OFS_ENABLE: begin
				rd_mux = {16'h0000, enable_reg};
			end
			`OFS_PRIO_LOW: begin
				rd_mux = {20'h00000, prio_low_reg};
			end
			`OFS_PRIO_HIGH: begin
				rd_mux = {20'h00000, prio_high_reg};
			end
			`OFS_FLAGS: begin
				rd_mux = {16'h0000, flag_reg[15:4], src_flag[2],
					flag_reg[2], src_flag[0], supply_warning_level};
			end
			`OFS_CONTROL: begin
				rd_mux = {27'h0000000, control_reg};
			end
			`OFS_STATUS: begin
				rd_mux = {16'h0000, call_vector, 3'h0, isr_reg};
			end
			default: begin
				rd_mux = 32'h00000000;
			end
		endcase
	end

	// Zero wait states, always OKAY.
	always @(posedge mclk) begin
		if (srst) begin
			addr_reg <= 8'h00;
			wr_pend_reg <= 1'b0;
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wr_pend_reg <= ahb_start && hwrite;
			if (ahb_start) begin
				addr_reg <= haddr[7:0];
			end
			if (ahb_start && !hwrite) begin
				hrdata <= rd_mux;
			end
		end
	end

endmodule // irq_ctrl

`default_nettype wire

// *** test/irq_ctrl_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none
// -----------------------------------------------------------------
// Port checks of the interrupt controller.
// -----------------------------------------------------------------
module irq_ctrl_assertions (
	input wire logic        mclk,
	input wire logic        srst,
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        last_cycle,
	input wire logic        insn_return_from_interrupt,
	input wire logic        insn_cfg_write,
	input wire logic        supply_warning_level,
	input wire logic        call_req,
	input wire logic [7:0]  call_vector
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);
	// A cycle in which the core allows no call to be decided.
	sequence s_blocked;
		!last_cycle || insn_return_from_interrupt || insn_cfg_write;
	endsequence
	// The call pulse and the quiet cycle after it.
	sequence s_pulse;
		call_req ##1 !call_req;
	endsequence
	a_call_after_last: assert property (call_req |-> $past(last_cycle))
		else $error("call without a final cycle");
	a_call_blocked: assert property (s_blocked |=> !call_req)
		else $error("call in a blocked cycle");
	a_call_pulse: assert property (call_req |-> s_pulse)
		else $error("call pulse too long");
	a_vector_legal: assert property (call_req |->
		call_vector[2:0] == 3'h3 && call_vector <= 8'h63)
		else $error("call vector off the table");
	a_vector_held: assert property (!call_req |-> $stable(call_vector))
		else $error("vector moved without a call");
	a_pf_level: assert property (call_req && call_vector == 8'h33 |->
		$past(supply_warning_level))
		else $error("power-fail call without supply low");
	a_resp_okay: assert property (!hresp)
		else $error("error response");
	a_ready_high: assert property (hreadyout)
		else $error("wait state inserted");
	a_rdata_held: assert property (!$past(hsel && htrans[1] && hready &&
		!hwrite) |-> $stable(hrdata))
		else $error("read data moved without a read");
endmodule // irq_ctrl_assertions

bind irq_ctrl irq_ctrl_assertions u_chk (
	.mclk(mclk), .srst(srst), .hsel(hsel), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .last_cycle(last_cycle),
	.insn_return_from_interrupt(insn_return_from_interrupt), .insn_cfg_write(insn_cfg_write),
	.supply_warning_level(supply_warning_level),
	.call_req(call_req), .call_vector(call_vector)
);
`default_nettype wire

// *** test/core_seq_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// -----------------------------------------------------------------
// Sequencer stand-in: three-cycle instructions while run is high.
// -----------------------------------------------------------------
module core_seq_model (
	input  wire logic mclk,
	input  wire logic srst,
	input  wire logic run,
	input  wire logic return_from_interrupt_req,
	input  wire logic cfg_req,
	output wire logic last_cycle,
	output var  logic insn_return_from_interrupt,
	output var  logic insn_cfg_write
);
	logic [1:0] phase_reg;	// Cycle within the instruction.
	// One-shot kinds stick until the end of the next instruction.
	always @(posedge mclk) begin
		if (srst) begin
			phase_reg <= 2'h0;
			insn_return_from_interrupt <= 1'b0;
			insn_cfg_write <= 1'b0;
		end else begin
			if (run)
				phase_reg <= last_cycle ? 2'h0 : phase_reg + 2'h1;
			insn_return_from_interrupt <= return_from_interrupt_req | (insn_return_from_interrupt & ~last_cycle);
			insn_cfg_write <= cfg_req | (insn_cfg_write & ~last_cycle);
		end
	end
	assign last_cycle = run && phase_reg == 2'h2;
endmodule // core_seq_model
`default_nettype wire

// *** test/tb.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "irq_ctrl_regs.vh"
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin \
	errors++; $display("MISMATCH %s exp %h got %h", n, e, s); end end
module tb;
	// -------------------------------------------------------------
	// Signals.
	// -------------------------------------------------------------
	logic        mclk = 0, srst = 1, hwrite = 0, hreadyout, hresp;
	logic [31:0] haddr = 0, hwdata = 0, hrdata;
	logic [1:0]  htrans = 0;
	logic        run = 0, return_from_interrupt_req = 0, cfg_req = 0, pm_mode = 0;
	logic        last_cycle, insn_return_from_interrupt, insn_cfg_write, call_req;
	logic [7:0]  call_vector, ev = 0;	// Event strobes tf0..wdt.
	logic [5:0]  pin = 6'h2B;	// Pins a..f, idle levels.
	logic        trig = 1, supply = 0;
	int          errors = 0, check_count = 0;
	always #20 mclk = ~mclk;
	irq_ctrl u_dut (.mclk(mclk), .srst(srst), .hsel(1'b1), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .last_cycle(last_cycle), .insn_return_from_interrupt(insn_return_from_interrupt),
		.insn_cfg_write(insn_cfg_write), .pm_mode(pm_mode),
		.call_req(call_req), .call_vector(call_vector),
		.ext_irq_a_n(pin[0]), .ext_irq_b_n(pin[1]), .ext_irq_c(pin[2]),
		.ext_irq_d_n(pin[3]), .ext_irq_e(pin[4]), .ext_irq_f_n(pin[5]),
		.timer2_trigger_pin(trig), .timer0_overflow(ev[0]),
		.timer1_overflow(ev[1]), .timer2_overflow(ev[2]),
		.serial0_rx_done(ev[3]), .serial0_tx_done(ev[4]),
		.serial1_rx_done(ev[5]), .serial1_tx_done(ev[6]),
		.watchdog_event(ev[7]), .supply_warning_level(supply));
	core_seq_model u_core (.mclk(mclk), .srst(srst), .run(run),
		.return_from_interrupt_req(return_from_interrupt_req), .cfg_req(cfg_req), .last_cycle(last_cycle),
		.insn_return_from_interrupt(insn_return_from_interrupt), .insn_cfg_write(insn_cfg_write));
	// -------------------------------------------------------------
	// Bus and core helpers.
	// -------------------------------------------------------------
	// Write; hw strobes events into the data phase to race it.
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [7:0] hw);
		@(posedge mclk);
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= 1'b1;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		ev <= hw;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		ev <= 8'h0;
	endtask
	// Read, then compare the masked word.
	task automatic rchk(input string n, input logic [7:0] a,
		input logic [31:0] m, input logic [31:0] e);
		@(posedge mclk);
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= 1'b0;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		`CHK(n, e, hrdata & m)
	endtask
	// Run ten instructions; op[0] asks a return, op[1] a config write.
	task automatic wait_call(input logic [7:0] v, input logic yes,
		input logic [1:0] op);
		logic got;
		got = 1'b0;
		@(posedge mclk);
		run <= 1'b1;
		return_from_interrupt_req <= op[0];
		cfg_req <= op[1];
		repeat (30) begin
			@(posedge mclk);
			return_from_interrupt_req <= 1'b0;
			cfg_req <= 1'b0;
			if (call_req === 1'b1 && !got) begin
				got = 1'b1;
				`CHK("call_vector", v, call_vector)
			end
		end
		run <= 1'b0;
		`CHK("call_taken", yes, got)
	endtask
	// -------------------------------------------------------------
	// Scenarios.
	// -------------------------------------------------------------
	task automatic t_reset_values;
		for (int i = 0; i < 7; i++)
			rchk("reset", (i == 6) ? 8'h40 : 8'(i * 4), '1, 0);
	endtask
	task automatic t_level_a;
		@(posedge mclk);
		pin[0] <= 1'b0;
		rchk("level_a", `OFS_FLAGS, 32'h2, 32'h2);
		wr(`OFS_FLAGS, 32'h0, 8'h0);
		rchk("level_a", `OFS_FLAGS, 32'h2, 32'h2);
		@(posedge mclk);
		pin[0] <= 1'b1;
		rchk("level_a", `OFS_FLAGS, 32'h2, 32'h0);
	endtask
	// Each pin to its active level, read while it still stands there.
	task automatic t_edge_pins;
		int fb[6] = '{`FLG_EXT_A, `FLG_EXT_B, `FLG_EXT_C,
			`FLG_EXT_D, `FLG_EXT_E, `FLG_EXT_F};
		wr(`OFS_CONTROL, 32'h3, 8'h0);
		for (int i = 0; i < 6; i++) begin
			@(posedge mclk);
			pin[i] <= ~pin[i];
			repeat (3) @(posedge mclk);
			rchk("edge", `OFS_FLAGS, 1 << fb[i], 1 << fb[i]);
			pin[i] <= ~pin[i];
			repeat (3) @(posedge mclk);
			wr(`OFS_FLAGS, 32'h0, 8'h0);
		end
	endtask
	task automatic t_events;
		int fb[8] = '{`FLG_TF0, `FLG_TF1, `FLG_TF2, `FLG_RI0,
			`FLG_TI0, `FLG_RI1, `FLG_TI1, `FLG_WDT};
		for (int i = 0; i < 8; i++) begin
			@(posedge mclk);
			ev <= 8'h1 << i;
			@(posedge mclk);
			ev <= 8'h0;
			rchk("event", `OFS_FLAGS, 32'hFFFE, 1 << fb[i]);
			wr(`OFS_FLAGS, 32'h0, 8'h0);
		end
	endtask
	// Capture, reload, reload counting both ways, trigger off.
	task automatic t_timer2;
		logic [7:0] cfg[4] = '{8'h0F, 8'h0B, 8'h1B, 8'h07};
		logic [3:0] hit = 4'h3;
		for (int i = 0; i < 4; i++) begin
			wr(`OFS_CONTROL, {24'h0, cfg[i]}, 8'h0);
			@(posedge mclk);
			trig <= 1'b0;
			repeat (3) @(posedge mclk);
			trig <= 1'b1;
			rchk("timer2_external_flag", `OFS_FLAGS, 32'h100, {hit[i], 8'h0});
			wr(`OFS_FLAGS, 32'h0, 8'h0);
		end
		wr(`OFS_CONTROL, 32'h3, 8'h0);
	endtask
	task automatic t_conflict;
		wr(`OFS_FLAGS, 32'h0, 8'h01);
		rchk("hw_wins", `OFS_FLAGS, 32'h4, 32'h4);
	endtask
	task automatic t_mask_and_call;
		wr(`OFS_ENABLE, 32'h0002, 8'h0);
		wait_call(8'h0, 1'b0, 2'h0);
		wr(`OFS_ENABLE, 32'h8002, 8'h0);
		wait_call(8'h0B, 1'b1, 2'h0);
		rchk("tf0_clr", `OFS_FLAGS, 32'h4, 32'h0);
	endtask
	task automatic t_preempt;
		wr(`OFS_FLAGS, 32'h0, 8'h01);
		wait_call(8'h0, 1'b0, 2'h0);
		wr(`OFS_PRIO_LOW, 32'h8, 8'h0);
		wr(`OFS_ENABLE, 32'h800A, 8'h0);
		wr(`OFS_FLAGS, 32'h0, 8'h02);
		wait_call(8'h1B, 1'b1, 2'h0);
		wr(`OFS_ENABLE, 32'h1000, 8'h0);
		supply <= 1'b1;
		wait_call(8'h33, 1'b1, 2'h0);
		rchk("in_service", `OFS_STATUS, 32'h1F, 32'h13);
		supply <= 1'b0;
		repeat (3) wait_call(8'h0, 1'b0, 2'h1);
		rchk("in_service", `OFS_STATUS, 32'h1F, 32'h0);
	endtask
	task automatic t_natural;
		wr(`OFS_PRIO_LOW, 32'h0, 8'h0);
		wr(`OFS_ENABLE, 32'h8880, 8'h0);
		wr(`OFS_FLAGS, 32'h8800, 8'h0);
		wait_call(8'h43, 1'b1, 2'h0);
		wait_call(8'h0, 1'b0, 2'h0);
		wr(`OFS_FLAGS, 32'h8000, 8'h0);
		wait_call(8'h63, 1'b1, 2'h1);
		wr(`OFS_FLAGS, 32'h0, 8'h0);
		wait_call(8'h0, 1'b0, 2'h1);
	endtask
	task automatic t_cancel;
		wr(`OFS_ENABLE, 32'h8010, 8'h0);
		wr(`OFS_FLAGS, 32'h20, 8'h0);
		wr(`OFS_FLAGS, 32'h0, 8'h0);
		wait_call(8'h0, 1'b0, 2'h0);
		wr(`OFS_FLAGS, 32'h20, 8'h0);
		wait_call(8'h23, 1'b1, 2'h2);
		rchk("ri0_kept", `OFS_FLAGS, 32'h20, 32'h20);
		wr(`OFS_FLAGS, 32'h0, 8'h0);
		rchk("in_service", `OFS_STATUS, 32'h1, 32'h1);
		wait_call(8'h0, 1'b0, 2'h1);
	endtask
	// Slow sampling: an edge held past two sampling periods is seen.
	task automatic t_power_mgmt;
		@(posedge mclk);
		pm_mode <= 1'b1;
		repeat (1100) @(posedge mclk);
		pin[4] <= 1'b1;
		repeat (2100) @(posedge mclk);
		rchk("pm_edge", `OFS_FLAGS, 32'h2000, 32'h2000);
		pm_mode <= 1'b0;
	endtask
	// -------------------------------------------------------------
	// Sequence, verdict and watchdog.
	// -------------------------------------------------------------
	task automatic final_report;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge mclk);
		srst <= 1'b0;
		t_reset_values;
		t_level_a;
		t_edge_pins;
		t_events;
		t_timer2;
		t_conflict;
		t_mask_and_call;
		t_preempt;
		t_natural;
		t_cancel;
		t_power_mgmt;
		final_report;
	end
	initial begin
		repeat (20000) @(posedge mclk);
		errors++;
		final_report;
	end
endmodule // tb
`default_nettype wire
